// >>> aasc_ctrl.sv
// Purpose: Arming, trigger placement, storage and run stop control.
// Assumes: Sequencer and memory share sys_clk_i; arm_ext_i is asynchronous.
// Notes:   One instance serves both local analyzers; index 0 is first.
`timescale 1ns/1ps
`default_nettype none
`include "aasc_map.svh"
module aasc_ctrl
  import aasc_pkg::*;
#(
  parameter int DW = 24,
  parameter int TW = 32
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  input  wire logic [1:0]          run_start_i,
  input  wire logic                repetitive_i,
  input  wire logic [1:0]          timing_mode_i,
  input  wire logic [1:0]          arm_from_peer_i,
  input  wire logic [1:0]          arm_from_ext_i,
  input  wire logic [3:0]          arm_level0_i,
  input  wire logic [3:0]          arm_level1_i,
  input  wire logic [3:0]          seq_level0_i,
  input  wire logic [3:0]          seq_level1_i,
  input  wire logic                arm_ext_i,
  input  wire aasc_out_sel_e       arm_out_sel_i,
  input  wire logic [1:0]          seq_trigger_i,
  input  wire logic [1:0]          seq_store_i,
  input  wire logic [1:0]          seq_branch_i,
  input  wire logic [1:0]          branch_store_en_i,
  input  wire logic [1:0]          sample_valid_i,
  input  wire logic [1:0]          auto_mode_i,
  input  wire logic [6:0]          man_pre_pct0_i,
  input  wire logic [6:0]          man_pre_pct1_i,
  input  wire logic [6:0]          auto_pre_pct0_i,
  input  wire logic [6:0]          auto_pre_pct1_i,
  input  wire logic [DW-1:0]       man_delay0_i,
  input  wire logic [DW-1:0]       man_delay1_i,
  input  wire logic [DW-1:0]       auto_delay0_i,
  input  wire logic [DW-1:0]       auto_delay1_i,
  input  wire logic [15:0]         man_period_i,
  input  wire logic [15:0]         auto_period_i,
  input  wire logic [DW-1:0]       depth_req0_i,
  input  wire logic [DW-1:0]       depth_req1_i,
  input  wire logic [1:0]          tag_en_i,
  input  wire logic [1:0]          all_pods_i,
  input  wire aasc_stop_e          stop_sel0_i,
  input  wire aasc_stop_e          stop_sel1_i,
  input  wire logic [1:0]          xo_ok_src_i,
  input  wire aasc_xo_cmp_e        xo_cmp_i,
  input  wire logic [TW-1:0]       xo_interval_i,
  input  wire logic [TW-1:0]       xo_limit_i,
  input  wire logic [1:0]          cmp_done_i,
  input  wire logic [1:0]          cmp_equal_i,
  input  wire logic [1:0]          cmp_want_eq_i,
  output logic      [1:0]          arm_term_o,
  output logic                     arm_out_o,
  output logic      [1:0]          trig_enable_o,
  output logic      [1:0]          triggered_o,
  output logic      [1:0]          store_o,
  output logic      [1:0]          running_o,
  output logic      [1:0]          prestore_short_o,
  output logic      [15:0]         sample_period_o,
  output logic      [4:0]          depth_log2_0_o,
  output logic      [4:0]          depth_log2_1_o,
  output logic signed [TW-1:0]     tag0_o,
  output logic signed [TW-1:0]     tag1_o,
  output logic                     rep_stop_o
);
  logic        ext_rise;
  logic [4:0]  rnd_log2 [2];
  logic [4:0]  eff_log2 [2];
  logic [DW:0] depth [2];
  logic [DW:0] pre_need [2];
  logic [DW:0] post_need [2];
  logic [DW:0] pre_cnt [2];
  logic [DW:0] post_cnt [2];
  logic [DW-1:0] dly_cnt [2];
  logic [DW-1:0] dly_sel [2];
  logic [6:0]  pct [2];
  logic [3:0]  arm_lvl [2];
  logic [3:0]  seq_lvl [2];
  logic [1:0]  arm_evt;
  logic [1:0]  trig_fire;
  logic [1:0]  want_store;
  logic [1:0]  stop_hit;
  logic [1:0]  ext_used;
  logic        xo_true;
  logic        xo_allowed [2];
  aasc_stop_e  stop_sel [2];
  logic signed [TW-1:0] tag [2];
  logic [TW-1:0] tag_step [2];

  aasc_edge_sync u_arm_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (arm_ext_i),
    .level_o   (),
    .rise_o    (ext_rise)
  );
  aasc_depth_round #(.W(DW)) u_round0 (
    .req_i  (depth_req0_i),
    .log2_o (rnd_log2[0])
  );
  aasc_depth_round #(.W(DW)) u_round1 (
    .req_i  (depth_req1_i),
    .log2_o (rnd_log2[1])
  );

  assign arm_lvl[0]  = arm_level0_i;
  assign arm_lvl[1]  = arm_level1_i;
  assign seq_lvl[0]  = seq_level0_i;
  assign seq_lvl[1]  = seq_level1_i;
  assign stop_sel[0] = stop_sel0_i;
  assign stop_sel[1] = stop_sel1_i;
  // Automatic mode takes placement from the display settings.
  assign pct[0] = auto_mode_i[0] ? auto_pre_pct0_i : man_pre_pct0_i;
  assign pct[1] = auto_mode_i[1] ? auto_pre_pct1_i : man_pre_pct1_i;
  assign dly_sel[0] = auto_mode_i[0] ? auto_delay0_i : man_delay0_i;
  assign dly_sel[1] = auto_mode_i[1] ? auto_delay1_i : man_delay1_i;
  assign ext_used = arm_from_ext_i;
  // Chain: the first analyzer's trigger arms the second when selected.
  assign arm_evt[0] = (arm_from_ext_i[0] & ext_rise)
                    | (arm_from_peer_i[0] & trig_fire[1]);
  assign arm_evt[1] = (arm_from_ext_i[1] & ext_rise)
                    | (arm_from_peer_i[1] & trig_fire[0]);
  assign xo_true = (xo_cmp_i == AASC_XO_LT) ? (xo_interval_i < xo_limit_i) :
                   (xo_cmp_i == AASC_XO_GT) ? (xo_interval_i > xo_limit_i) :
                   (xo_interval_i == xo_limit_i);

  for (genvar a = 0; a < 2; a++) begin : g_an
    // Halving applies only in state mode with tags and all pods taken.
    assign eff_log2[a] = (!timing_mode_i[a] && tag_en_i[a] && all_pods_i[a])
                       ? rnd_log2[a] - 5'd1 : rnd_log2[a];
    assign depth[a] = (DW+1)'(1) << eff_log2[a];
    // Timing keeps a floor of samples on both sides of the trigger.
    always_comb begin
      pre_need[a] = (DW+1)'((32'(depth[a]) * 32'(pct[a])) / `AASC_PCT_FULL);
      if (timing_mode_i[a]) begin
        if (pre_need[a] < (DW+1)'(`AASC_EDGE_KEEP)) begin
          pre_need[a] = (DW+1)'(`AASC_EDGE_KEEP);
        end
        if (pre_need[a] > depth[a] - (DW+1)'(`AASC_EDGE_KEEP)) begin
          pre_need[a] = depth[a] - (DW+1)'(`AASC_EDGE_KEEP);
        end
      end
    end
    assign post_need[a] = depth[a] - pre_need[a];
    // Timing mode holds off the trigger until the prestore is filled.
    assign trig_enable_o[a] = running_o[a] & ~triggered_o[a]
                            & (~timing_mode_i[a] | pre_cnt[a] >= pre_need[a]);
    assign trig_fire[a] = trig_enable_o[a] & seq_trigger_i[a];
    assign want_store[a] = sample_valid_i[a] & (seq_store_i[a]
                         | (seq_branch_i[a] & branch_store_en_i[a]
                            & ~timing_mode_i[a]));
    assign xo_allowed[a] = timing_mode_i[a] | tag_en_i[a];
    // Marker display has no input here, so it cannot mask a stop.
    assign stop_hit[a] = running_o[a] & repetitive_i & (
        (stop_sel[a] == AASC_STOP_XO && xo_allowed[a]
         && xo_ok_src_i[a] && xo_true)
      | (stop_sel[a] == AASC_STOP_CMP && cmp_done_i[a]
         && (cmp_equal_i[a] == cmp_want_eq_i[a])));
    assign tag_step[a] = timing_mode_i[a] ? TW'(1) :
                         (tag_en_i[a] ? TW'(1) : TW'(0));

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        arm_term_o[a]       <= 1'b0;
        triggered_o[a]      <= 1'b0;
        running_o[a]        <= 1'b0;
        prestore_short_o[a] <= 1'b0;
        store_o[a]          <= 1'b0;
        pre_cnt[a]          <= '0;
        post_cnt[a]         <= '0;
        dly_cnt[a]          <= '0;
        tag[a]              <= '0;
      end else if (run_start_i[a]) begin
        arm_term_o[a]       <= 1'b0;
        triggered_o[a]      <= 1'b0;
        running_o[a]        <= 1'b1;
        prestore_short_o[a] <= 1'b0;
        store_o[a]          <= 1'b0;
        pre_cnt[a]          <= '0;
        post_cnt[a]         <= '0;
        dly_cnt[a]          <= '0;
        tag[a]              <= '0;
      end else begin
        store_o[a] <= 1'b0;
        // Arm is latched once; it stays true until the next run.
        if (arm_evt[a] && running_o[a] && arm_lvl[a] != 4'd0) begin
          arm_term_o[a] <= 1'b1;
        end
        if (stop_hit[0] || stop_hit[1]) begin
          running_o[a] <= 1'b0;
        end else if (trig_fire[a]) begin
          triggered_o[a] <= 1'b1;
          // Pre-trigger tags count down from zero; the trigger restarts the tag at zero.
          tag[a] <= '0;
          if (!timing_mode_i[a] && pre_cnt[a] < pre_need[a]) begin
            prestore_short_o[a] <= 1'b1;
          end
          dly_cnt[a] <= timing_mode_i[a] ? dly_sel[a] : '0;
        end else if (running_o[a] && !triggered_o[a]) begin
          if (want_store[a]) begin
            store_o[a] <= 1'b1;
            if (pre_cnt[a] < depth[a]) begin
              pre_cnt[a] <= pre_cnt[a] + (DW+1)'(1);
            end
            tag[a] <= tag[a] - $signed(tag_step[a]);
          end
        end else if (running_o[a]) begin
          if (dly_cnt[a] != '0) begin
            dly_cnt[a] <= dly_cnt[a] - DW'(1);
          end else if (post_cnt[a] >= post_need[a]) begin
            running_o[a] <= 1'b0;
          end else if (want_store[a]) begin
            store_o[a]    <= 1'b1;
            post_cnt[a]   <= post_cnt[a] + (DW+1)'(1);
            tag[a]        <= tag[a] + $signed(tag_step[a]);
          end
        end
      end
    end
  end

  // The arm term feeds the sequencer as an ordinary resource term, so
  // a level before the armed one may still trigger first.
  logic [1:0] next_seq_ok;
  assign next_seq_ok[0] = arm_term_o[0] | (seq_lvl[0] != arm_lvl[0]);
  assign next_seq_ok[1] = arm_term_o[1] | (seq_lvl[1] != arm_lvl[1]);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      arm_out_o       <= 1'b0;
      sample_period_o <= 16'h0000;
      depth_log2_0_o  <= 5'h00;
      depth_log2_1_o  <= 5'h00;
      tag0_o          <= '0;
      tag1_o          <= '0;
      rep_stop_o      <= 1'b0;
    end else begin
      arm_out_o <= (arm_out_sel_i == AASC_OUT_AN0 && trig_fire[0])
                 | (arm_out_sel_i == AASC_OUT_AN1 && trig_fire[1]);
      sample_period_o <= auto_mode_i[0] ? auto_period_i : man_period_i;
      depth_log2_0_o  <= eff_log2[0];
      depth_log2_1_o  <= eff_log2[1];
      tag0_o          <= tag[0];
      tag1_o          <= tag[1];
      rep_stop_o      <= (stop_hit[0] | stop_hit[1]) | (rep_stop_o
                         & ~(run_start_i[0] | run_start_i[1]));
    end
  end

  property p_arm_once;
    @(posedge sys_clk_i) disable iff (rst_i)
    arm_term_o[0] && !run_start_i[0] |=> arm_term_o[0];
  endproperty
  a_arm_once: assert property (p_arm_once)
    else $error("arm term dropped");
  sequence s_peer_arm;
    arm_evt[1] && running_o[1] && arm_lvl[1] != 4'd0;
  endsequence
  property p_arm_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    s_peer_arm ##0 !run_start_i[1] |=> arm_term_o[1];
  endproperty
  a_arm_set: assert property (p_arm_set)
    else $error("arm event not taken");
  property p_timing_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    timing_mode_i[0] && pre_cnt[0] < pre_need[0] |-> !trig_fire[0];
  endproperty
  a_timing_hold: assert property (p_timing_hold)
    else $error("trigger before prestore");
  // A stop or a restart in the same cycle wins over the trigger.
  sequence s_short_trig;
    !timing_mode_i[0] && trig_fire[0] && pre_cnt[0] < pre_need[0];
  endsequence
  sequence s_no_abort;
    !stop_hit[0] && !stop_hit[1] && !run_start_i[0];
  endsequence
  property p_short_flag;
    @(posedge sys_clk_i) disable iff (rst_i)
    s_short_trig ##0 s_no_abort |=> triggered_o[0] && prestore_short_o[0];
  endproperty
  a_short_flag: assert property (p_short_flag)
    else $error("short prestore not flagged");
  sequence s_post_full;
    triggered_o[0] && running_o[0] && dly_cnt[0] == '0
    && post_cnt[0] >= post_need[0];
  endsequence
  property p_halt;
    @(posedge sys_clk_i) disable iff (rst_i)
    s_post_full ##0 !run_start_i[0] |=> !running_o[0];
  endproperty
  a_halt: assert property (p_halt)
    else $error("run not halted when memory full");
  property p_stop_both;
    @(posedge sys_clk_i) disable iff (rst_i)
    stop_hit[0] && !run_start_i[1] |=> !running_o[1];
  endproperty
  a_stop_both: assert property (p_stop_both)
    else $error("peer not stopped");
  property p_out;
    @(posedge sys_clk_i) disable iff (rst_i)
    arm_out_sel_i == AASC_OUT_NONE |=> !arm_out_o;
  endproperty
  a_out: assert property (p_out)
    else $error("arm out without source");
  property p_branch_t;
    @(posedge sys_clk_i) disable iff (rst_i)
    timing_mode_i[0] && !seq_store_i[0] |-> !want_store[0];
  endproperty
  a_branch_t: assert property (p_branch_t)
    else $error("branch store in timing");
  property p_pre_neg;
    @(posedge sys_clk_i) disable iff (rst_i)
    running_o[0] && !triggered_o[0] |-> tag[0] <= 0;
  endproperty
  a_pre_neg: assert property (p_pre_neg)
    else $error("pre tag positive");
  property p_post_pos;
    @(posedge sys_clk_i) disable iff (rst_i)
    triggered_o[0] |-> tag[0] >= 0;
  endproperty
  a_post_pos: assert property (p_post_pos)
    else $error("post tag negative");
  property p_keep;
    @(posedge sys_clk_i) disable iff (rst_i)
    timing_mode_i[0] |-> pre_need[0] >= (DW+1)'(`AASC_EDGE_KEEP);
  endproperty
  a_keep: assert property (p_keep)
    else $error("no pre samples kept");
  wire unused_ok = |next_seq_ok | |ext_used;
endmodule : aasc_ctrl
`default_nettype wire

// >>> aasc_map.svh
// Purpose: Constants for the acquisition arm and store control block.
// Assumes: Acquisition clock of 100 MHz.
// Notes:   Depth codes select power-of-two memory sizes.
`ifndef AASC_MAP_SVH
`define AASC_MAP_SVH
`define AASC_CLK_PERIOD_NS    10
`define AASC_TAG_RES_NS       8
`define AASC_DLY_MIN_NS       16
`define AASC_DLY_MIN_CYC      ((`AASC_DLY_MIN_NS + `AASC_CLK_PERIOD_NS - 1) / `AASC_CLK_PERIOD_NS)
`define AASC_TAG_STEP_NS      `AASC_CLK_PERIOD_NS
`define AASC_DEPTH_MIN_LOG2   9
`define AASC_DEPTH_MAX_LOG2   21
`define AASC_EDGE_KEEP        4
`define AASC_PCT_FULL         100
`endif

// >>> aasc_pkg.sv
// Purpose: Types for the acquisition arm and store control block.
// Assumes: Nothing beyond the constants header.
// Notes:   Enumerations only.
package aasc_pkg;
  typedef enum logic [1:0] {
    AASC_OUT_NONE,
    AASC_OUT_AN0,
    AASC_OUT_AN1
  } aasc_out_sel_e;
  typedef enum logic [1:0] {
    AASC_STOP_OFF,
    AASC_STOP_XO,
    AASC_STOP_CMP
  } aasc_stop_e;
  typedef enum logic [1:0] {
    AASC_XO_LT,
    AASC_XO_GT,
    AASC_XO_EQ
  } aasc_xo_cmp_e;
endpackage : aasc_pkg

// >>> aasc_edge_sync.sv
// Purpose: Synchronise an outside level and mark its rising edges.
// Assumes: One acquisition clock.
// Notes:   Stage one is read only by stage two.
`timescale 1ns/1ps
`default_nettype none
module aasc_edge_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o
);
  logic stage1;
  logic stage2;
  logic stage3;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end
  assign level_o = stage2;
  assign rise_o  = stage2 & ~stage3;
endmodule : aasc_edge_sync
`default_nettype wire

// >>> aasc_depth_round.sv
// Purpose: Round a requested sample count to the nearest supported depth.
// Assumes: Supported depths are powers of two within a fixed span.
// Notes:   Ties round upward; out-of-span requests clamp.
`timescale 1ns/1ps
`default_nettype none
`include "aasc_map.svh"
module aasc_depth_round #(
  parameter int W = 24
) (
  input  wire logic [W-1:0] req_i,
  output logic      [4:0]   log2_o
);
  logic [4:0] msb;
  logic       up;
  always_comb begin
    msb = 5'd0;
    for (int i = 0; i < W; i++) begin
      if (req_i[i]) begin
        msb = 5'(i);
      end
    end
  end
  // Above the midpoint of two powers rounds to the higher one.
  assign up = (msb > 5'd0) ? req_i[msb-5'd1] : 1'b0;
  always_comb begin
    log2_o = msb + {4'd0, up};
    if (log2_o < 5'(`AASC_DEPTH_MIN_LOG2)) begin
      log2_o = 5'(`AASC_DEPTH_MIN_LOG2);
    end
    if (log2_o > 5'(`AASC_DEPTH_MAX_LOG2)) begin
      log2_o = 5'(`AASC_DEPTH_MAX_LOG2);
    end
  end
endmodule : aasc_depth_round
`default_nettype wire

// >>> aasc_peer.sv
// Purpose: Far-side instrument on the arm ports of the control block.
// Assumes: Acquisition clock drives the model's sampling.
// Notes:   Arm pulse edges land off the clock edge, as from a cable.
`timescale 1ns/1ps
`default_nettype none
module aasc_peer (
  input  wire logic sys_clk_i,
  input  wire logic fire_i,
  input  wire logic arm_out_i,
  output logic      arm_ext_o,
  output int        armed_cnt_o
);
  initial arm_ext_o = 1'b0;
  initial armed_cnt_o = 0;
  // The level is held three cycles so the synchroniser cannot miss it.
  always @(posedge sys_clk_i) begin
    if (fire_i === 1'b1) begin
      #3 arm_ext_o = 1'b1;
      repeat (3) @(posedge sys_clk_i);
      #3 arm_ext_o = 1'b0;
    end
  end
  // A downstream instrument counts each arm it receives.
  always @(posedge sys_clk_i) begin
    if (arm_out_i === 1'b1) armed_cnt_o <= armed_cnt_o + 1;
  end
endmodule : aasc_peer
`default_nettype wire

// >>> acquisition_arm_store_control_test.sv
// Purpose: Self-checking bench for the arm and store control block.
// Assumes: 100 MHz clock, synchronous active-high reset.
// Notes:   Depth 512 keeps fill runs short.
`timescale 1ns/1ps
`default_nettype none
module acquisition_arm_store_control_test;
  import aasc_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, repetitive_i = 1'b0, fire = 1'b0;
  logic [1:0] run_start_i = '0, timing_mode_i = '0, arm_from_peer_i = '0;
  logic [1:0] arm_from_ext_i = '0, seq_trigger_i = '0, seq_store_i = '0;
  logic [1:0] seq_branch_i = '0, branch_store_en_i = '0, auto_mode_i = '0;
  logic [1:0] sample_valid_i = 2'b11, tag_en_i = '0, all_pods_i = '0;
  logic [1:0] xo_ok_src_i = '0, cmp_done_i = '0, cmp_equal_i = '0;
  logic [1:0] cmp_want_eq_i = '0;
  logic [3:0] arm_level0_i = 4'h1, arm_level1_i = 4'h2;
  logic [3:0] seq_level0_i = 4'h1, seq_level1_i = 4'h2;
  aasc_out_sel_e arm_out_sel_i = AASC_OUT_NONE;
  aasc_stop_e    stop_sel0_i = AASC_STOP_OFF, stop_sel1_i = AASC_STOP_OFF;
  aasc_xo_cmp_e  xo_cmp_i = AASC_XO_GT;
  logic [6:0]  man_pre_pct0_i = '0, man_pre_pct1_i = '0;
  logic [6:0]  auto_pre_pct0_i = 7'h32, auto_pre_pct1_i = 7'h32;
  logic [23:0] man_delay0_i = '0, man_delay1_i = '0, auto_delay0_i = '0;
  logic [23:0] auto_delay1_i = '0, depth_req0_i = 24'h00_0200;
  logic [23:0] depth_req1_i = 24'h00_0200;
  logic [15:0] man_period_i = 16'h0040, auto_period_i = 16'h0020;
  logic [31:0] xo_interval_i = 32'h0000_0064, xo_limit_i = 32'h0000_0032;
  logic [1:0]  arm_term_o, trig_enable_o, triggered_o, store_o, running_o;
  logic [1:0]  prestore_short_o;
  logic        arm_out_o, rep_stop_o;
  logic [15:0] sample_period_o;
  logic [4:0]  depth_log2_0_o, depth_log2_1_o;
  logic signed [31:0] tag0_o, tag1_o;
  wire         arm_ext_i;
  int          armed_cnt, st0, fail_count = 0, tests_run = 0;

  aasc_ctrl uut (.sys_clk_i, .rst_i, .run_start_i, .repetitive_i,
    .timing_mode_i, .arm_from_peer_i, .arm_from_ext_i, .arm_level0_i,
    .arm_level1_i, .seq_level0_i, .seq_level1_i, .arm_ext_i, .arm_out_sel_i,
    .seq_trigger_i, .seq_store_i, .seq_branch_i, .branch_store_en_i,
    .sample_valid_i, .auto_mode_i, .man_pre_pct0_i, .man_pre_pct1_i,
    .auto_pre_pct0_i, .auto_pre_pct1_i, .man_delay0_i, .man_delay1_i,
    .auto_delay0_i, .auto_delay1_i, .man_period_i, .auto_period_i,
    .depth_req0_i, .depth_req1_i, .tag_en_i, .all_pods_i, .stop_sel0_i,
    .stop_sel1_i, .xo_ok_src_i, .xo_cmp_i, .xo_interval_i, .xo_limit_i,
    .cmp_done_i, .cmp_equal_i, .cmp_want_eq_i, .arm_term_o, .arm_out_o,
    .trig_enable_o, .triggered_o, .store_o, .running_o, .prestore_short_o,
    .sample_period_o, .depth_log2_0_o, .depth_log2_1_o, .tag0_o, .tag1_o,
    .rep_stop_o);
  aasc_peer peer (.sys_clk_i, .fire_i(fire), .arm_out_i(arm_out_o),
    .arm_ext_o(arm_ext_i), .armed_cnt_o(armed_cnt));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (store_o[0] === 1'b1) st0 <= st0 + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tk
  task automatic rs;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
  endtask : rs
  // Start pulse is one cycle wide; the store count restarts with the run.
  task automatic go(input logic [1:0] m);
    @(posedge sys_clk_i);
    run_start_i <= m;
    @(posedge sys_clk_i);
    run_start_i <= 2'b00;
    st0 = 0;
    #1;
  endtask : go

  task automatic t_config;
    logic [23:0] req [6] = '{24'h00_0064, 24'h00_0258, 24'h00_0300,
                             24'h00_03E8, 24'h01_0000, 24'hFF_FFFF};
    logic [4:0]  exp [6] = '{5'h09, 5'h09, 5'h0A, 5'h0A, 5'h10, 5'h15};
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk_i);
      depth_req0_i <= req[i];
      depth_req1_i <= req[i];
      tk(2);
      chk(depth_log2_0_o, exp[i], "depth 0");
      chk(depth_log2_1_o, exp[i], "depth 1");
    end
    @(posedge sys_clk_i);
    depth_req0_i <= 24'h00_0400;
    tag_en_i <= 2'b11;
    all_pods_i <= 2'b01;
    auto_mode_i <= 2'b11;
    tk(2);
    chk(depth_log2_0_o, 5'h09, "halved depth");
    chk(sample_period_o, 16'h0020, "auto period");
    @(posedge sys_clk_i);
    all_pods_i <= 2'b00;
    auto_mode_i <= 2'b00;
    tk(2);
    chk(depth_log2_0_o, 5'h0A, "full depth");
    chk(sample_period_o, 16'h0040, "manual period");
    @(posedge sys_clk_i);
    depth_req0_i <= 24'h00_0200;
    depth_req1_i <= 24'h00_0200;
    tag_en_i <= 2'b00;
    $display("done t_config");
  endtask : t_config

  task automatic t_timing;
    int n;
    for (int k = 0; k < 2; k++) begin
      rs();
      @(posedge sys_clk_i);
      timing_mode_i <= 2'b11;
      man_pre_pct0_i <= k ? 7'h00 : 7'h0A;
      seq_trigger_i <= 2'b01;
      seq_store_i <= 2'b01;
      arm_out_sel_i <= AASC_OUT_AN0;
      go(2'b01);
      chk(trig_enable_o[0], 1'b0, "early trigger");
      for (n = 0; n < 200 && triggered_o[0] !== 1'b1; n++) tk(1);
      chk(n >= (k ? 4 : 40), 1'b1, "pre gate");
      chk(arm_out_o, 1'b1, "arm out");
      for (n = 0; n < 700 && running_o[0] !== 1'b0; n++) tk(1);
      chk(st0, 512, "stored total");
      chk(armed_cnt, k + 1, "downstream armed");
    end
    $display("done t_timing");
  endtask : t_timing

  task automatic t_state;
    int s;
    rs();
    @(posedge sys_clk_i);
    timing_mode_i <= 2'b00;
    tag_en_i <= 2'b01;
    man_pre_pct0_i <= 7'h32;
    seq_trigger_i <= 2'b00;
    seq_store_i <= 2'b00;
    seq_branch_i <= 2'b01;
    arm_from_peer_i <= 2'b10;
    go(2'b11);
    chk(trig_enable_o[0], 1'b1, "state enable");
    s = st0;
    tk(4);
    chk(st0, s, "branch off");
    @(posedge sys_clk_i);
    branch_store_en_i <= 2'b01;
    tk(4);
    chk(st0 > s, 1'b1, "branch on");
    chk(tag0_o[31], 1'b1, "pre tag sign");
    chk(arm_term_o[1], 1'b0, "not armed");
    @(posedge sys_clk_i);
    seq_trigger_i <= 2'b01;
    @(posedge sys_clk_i);
    seq_trigger_i <= 2'b00;
    seq_store_i <= 2'b01;
    tk(1);
    chk(triggered_o[0], 1'b1, "state trigger");
    chk(prestore_short_o[0], 1'b1, "short prestore");
    tk(3);
    chk(arm_term_o[1], 1'b1, "peer armed");
    tk(6);
    chk({tag0_o[31], tag0_o == 0}, 2'b00, "post tag sign");
    $display("done t_state");
  endtask : t_state

  task automatic t_ext;
    int n;
    rs();
    chk({arm_term_o, triggered_o, running_o, rep_stop_o}, 0, "reset");
    @(posedge sys_clk_i);
    fire <= 1'b1;
    arm_out_sel_i <= AASC_OUT_NONE;
    @(posedge sys_clk_i);
    fire <= 1'b0;
    tk(8);
    chk(arm_term_o, 2'b00, "ext unused");
    @(posedge sys_clk_i);
    arm_from_ext_i <= 2'b01;
    go(2'b01);
    @(posedge sys_clk_i);
    fire <= 1'b1;
    @(posedge sys_clk_i);
    fire <= 1'b0;
    for (n = 0; n < 8 && arm_term_o[0] !== 1'b1; n++) tk(1);
    chk(arm_term_o[0], 1'b1, "ext arm");
    n = armed_cnt;
    @(posedge sys_clk_i);
    seq_trigger_i <= 2'b01;
    tk(4);
    chk(armed_cnt, n, "no arm out");
    $display("done t_ext");
  endtask : t_ext

  task automatic t_stop;
    rs();
    @(posedge sys_clk_i);
    repetitive_i <= 1'b1;
    seq_trigger_i <= 2'b00;
    cmp_done_i <= 2'b11;
    cmp_equal_i <= 2'b11;
    cmp_want_eq_i <= 2'b11;
    go(2'b11);
    tk(4);
    chk(rep_stop_o, 1'b0, "stop off");
    @(posedge sys_clk_i);
    stop_sel1_i <= AASC_STOP_CMP;
    tk(4);
    chk(rep_stop_o, 1'b1, "cmp equal");
    chk(running_o, 2'b00, "both stop");
    rs();
    @(posedge sys_clk_i);
    cmp_want_eq_i <= 2'b00;
    go(2'b11);
    tk(4);
    chk(rep_stop_o, 1'b0, "cmp neq wait");
    @(posedge sys_clk_i);
    cmp_equal_i <= 2'b00;
    tk(4);
    chk(rep_stop_o, 1'b1, "cmp neq");
    rs();
    @(posedge sys_clk_i);
    cmp_done_i <= 2'b00;
    stop_sel1_i <= AASC_STOP_OFF;
    stop_sel0_i <= AASC_STOP_XO;
    tag_en_i <= 2'b00;
    xo_ok_src_i <= 2'b11;
    go(2'b11);
    tk(4);
    chk(rep_stop_o, 1'b0, "marker stop refused");
    @(posedge sys_clk_i);
    timing_mode_i <= 2'b11;
    tk(4);
    chk(rep_stop_o, 1'b1, "marker stop");
    chk(running_o, 2'b00, "both stop xo");
    $display("done t_stop");
  endtask : t_stop

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Runs take about 1200 cycles in all; the 20000-cycle limit leaves wide margin.
  initial begin
    #200_000;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_config();
    t_timing();
    t_state();
    t_ext();
    t_stop();
    end_of_test();
  end
endmodule : acquisition_arm_store_control_test
`default_nettype wire
